// >>> include/csa_consts.svh
// Purpose : offsets, field positions, reset values and scaling constants
//           for the chroma saturation / hue adjust stage
// Assumes : byte addresses on an 8-bit register port
// Notes   : definitions only
`ifndef CSA_CONSTS_SVH
`define CSA_CONSTS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define CSA_OFF_EVEN_CTL   8'h2c
`define CSA_OFF_ODD_CTL    8'hac
`define CSA_OFF_U_LOW      8'h34
`define CSA_OFF_V_LOW      8'h38
`define CSA_OFF_HUE        8'h3c
`define CSA_OFF_EVEN_LOOP  8'h40
`define CSA_OFF_ODD_LOOP   8'hc0

// ****************************************************************
// reset values
// ****************************************************************
`define CSA_RST_CTL        8'h20
`define CSA_RST_U_LOW      8'hfe
`define CSA_RST_V_LOW      8'hb4
`define CSA_RST_HUE        8'h00
`define CSA_RST_LOOP       8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define CSA_CTL_U_TOP      1
`define CSA_CTL_V_TOP      0
`define CSA_LOOP_PEAK      7
`define CSA_LOOP_HF_HI     4
`define CSA_LOOP_HF_LO     3

// ****************************************************************
// gain and phase scaling, output FIFO depth
// ****************************************************************
`define CSA_U_UNITY        9'h0fe
`define CSA_V_UNITY        9'h0b4
`define CSA_U_RECIP        10'h102
`define CSA_V_RECIP        10'h16c
`define CSA_RECIP_SHIFT    16
`define CSA_ROUND          32'h0000_8000
`define CSA_CHROMA_ZERO    32'h0000_0080
`define CSA_CHROMA_MIN     8'h02
`define CSA_CHROMA_MAX     8'hfd
`define CSA_HUE_PHASE_STEP 16'h007f
`define CSA_FIFO_DEPTH     8

`endif

// >>> include/csa_pkg.sv
// Purpose : types shared by the chroma saturation / hue adjust stage
// Assumes : nothing
// Notes   : constants live in csa_consts.svh
package csa_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csa_reg_req_t;

    typedef struct packed {
        logic [15:0] phase;
        logic [7:0]  u;
        logic [7:0]  v;
    } csa_pix_t;

    typedef enum logic [2:0] {
        CSA_LP_AUTO,
        CSA_LP_CIF,
        CSA_LP_QCIF,
        CSA_LP_ICON,
        CSA_PEAK_NONE,
        CSA_PEAK_MIN,
        CSA_PEAK_MED,
        CSA_PEAK_MAX
    } csa_luma_mode_t;

endpackage

// >>> verilog/csa_adjust.sv
// Purpose : chroma saturation gain and hue phase offset stage, with its
//           register file and an output FIFO
// Assumes : one clock, chroma in offset binary (128 = no colour)
// Notes   : csa_fifo and csa_adjust share this file
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "csa_consts.svh"

// ****************************************************************
// csa_fifo: synchronous FIFO with valid/ready on both sides
// ****************************************************************
module csa_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    input  wire logic             i_s_valid,
    output logic                  o_s_ready,
    input  wire logic [WIDTH-1:0] i_s_data,
    output logic                  o_m_valid,
    input  wire logic             i_m_ready,
    output logic [WIDTH-1:0]      o_m_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign o_s_ready = (count_q != (AW+1)'(DEPTH));
    assign o_m_valid = (count_q != '0);
    assign push      = i_s_valid && o_s_ready;
    assign pop       = o_m_valid && i_m_ready;
    assign o_m_data  = mem_q[rd_ptr_q];

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_s_data;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
            end
            if (push && !pop) begin
                count_q <= (AW+1)'(count_q + 1'b1);
            end else if (pop && !push) begin
                count_q <= (AW+1)'(count_q - 1'b1);
            end
        end
    end

    default clocking cb_fifo @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    chk_fifo_no_over : assert property (
        count_q == (AW+1)'(DEPTH) |-> !o_s_ready)
        else $error("fifo accepts data while full");
    chk_fifo_count_step : assert property (
        push && !pop |=> count_q == (AW+1)'($past(count_q) + 1'b1))
        else $error("fifo count did not rise on push");
    cov_fifo_full : cover property (count_q == (AW+1)'(DEPTH));

endmodule // csa_fifo

// ****************************************************************
// csa_adjust: registers, gain/hue datapath, luma filter select
// ****************************************************************
// Notes on behaviour
// - u gain is control bit plus low byte
// - v gain is control bit plus low byte
// - u scaled by gain, 254 is unity
// - u low byte resets to 0xfe
// - v scaled by gain, 180 is unity
// - v low byte resets to 0xb4
// - signed hue added to subcarrier phase
// - 256 hue steps, 0.7 degrees each
// - hue resets to zero
// - even/odd loop control chosen by field
// - both loop controls reset to zero
// - peak bit picks peaking over low-pass
// - control bit1 u top, bit0 v top
// - peaking codes 01/10/11 are min/med/max
module csa_adjust (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_reset,
    input  wire csa_pkg::csa_reg_req_t  i_reg,
    output logic [7:0]                  o_rdata,
    input  wire logic                   i_field_odd,
    input  wire logic                   i_in_valid,
    output logic                        o_in_ready,
    input  wire csa_pkg::csa_pix_t      i_in_pix,
    output logic                        o_out_valid,
    input  wire logic                   i_out_ready,
    output csa_pkg::csa_pix_t           o_out_pix,
    output csa_pkg::csa_luma_mode_t     o_luma_mode
);
    import csa_pkg::*;

    logic [7:0]     even_ctl_q;
    logic [7:0]     odd_ctl_q;
    logic [7:0]     u_low_q;
    logic [7:0]     v_low_q;
    logic [7:0]     hue_q;
    logic [7:0]     even_loop_q;
    logic [7:0]     odd_loop_q;
    logic [7:0]     rdata_d;
    logic [7:0]     rdata_q;
    logic [7:0]     ctl_sel;
    logic [7:0]     loop_sel;
    logic [8:0]     u_gain_value;
    logic [8:0]     v_gain_value;
    logic [15:0]    hue_offset;
    logic           in_fire;
    csa_pix_t       adj_pix;

    // ****************************************************************
    // address decode helpers
    // ****************************************************************
    function automatic logic csa_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic csa_wr_hit(input csa_reg_req_t r,
                                        input logic [7:0] off);
        return r.wr && csa_hit(r.addr, off);
    endfunction

    // ****************************************************************
    // register file
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            even_ctl_q <= `CSA_RST_CTL;
            odd_ctl_q  <= `CSA_RST_CTL;
        end else begin
            if (csa_wr_hit(i_reg, `CSA_OFF_EVEN_CTL)) begin
                even_ctl_q <= i_reg.wdata;
            end
            if (csa_wr_hit(i_reg, `CSA_OFF_ODD_CTL)) begin
                odd_ctl_q <= i_reg.wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            u_low_q <= `CSA_RST_U_LOW;
            v_low_q <= `CSA_RST_V_LOW;
        end else begin
            if (csa_wr_hit(i_reg, `CSA_OFF_U_LOW)) begin
                u_low_q <= i_reg.wdata;
            end
            if (csa_wr_hit(i_reg, `CSA_OFF_V_LOW)) begin
                v_low_q <= i_reg.wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            hue_q <= `CSA_RST_HUE;
        end else if (csa_wr_hit(i_reg, `CSA_OFF_HUE)) begin
            hue_q <= i_reg.wdata;
        end
    end

    // reserved bits are stored as written; software keeps them zero
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            even_loop_q <= `CSA_RST_LOOP;
            odd_loop_q  <= `CSA_RST_LOOP;
        end else begin
            if (csa_wr_hit(i_reg, `CSA_OFF_EVEN_LOOP)) begin
                even_loop_q <= i_reg.wdata;
            end
            if (csa_wr_hit(i_reg, `CSA_OFF_ODD_LOOP)) begin
                odd_loop_q <= i_reg.wdata;
            end
        end
    end

    // ****************************************************************
    // read port: data stand in the cycle after the strobe
    // ****************************************************************
    always_comb begin
        rdata_d = 8'h00;
        if (i_reg.rd) begin
            unique case (i_reg.addr)
                `CSA_OFF_EVEN_CTL:  rdata_d = even_ctl_q;
                `CSA_OFF_ODD_CTL:   rdata_d = odd_ctl_q;
                `CSA_OFF_U_LOW:     rdata_d = u_low_q;
                `CSA_OFF_V_LOW:     rdata_d = v_low_q;
                `CSA_OFF_HUE:       rdata_d = hue_q;
                `CSA_OFF_EVEN_LOOP: rdata_d = even_loop_q;
                `CSA_OFF_ODD_LOOP:  rdata_d = odd_loop_q;
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // ****************************************************************
    // field copy selection and gain assembly
    // ****************************************************************
    assign ctl_sel  = i_field_odd ? odd_ctl_q : even_ctl_q;
    assign loop_sel = i_field_odd ? odd_loop_q : even_loop_q;

    assign u_gain_value = {ctl_sel[`CSA_CTL_U_TOP], u_low_q};
    assign v_gain_value = {ctl_sel[`CSA_CTL_V_TOP], v_low_q};

    // ****************************************************************
    // chroma scaling: (c-128)*gain/unity, rounded, then clipped
    // ****************************************************************
    function automatic logic [7:0] csa_scale(input logic [7:0] c,
                                             input logic [8:0] g,
                                             input logic [9:0] r);
        logic signed [31:0] x;
        logic signed [31:0] p;
        logic signed [31:0] y;
        logic        [31:0] o;
        x = $signed({24'h00_0000, c}) - $signed(`CSA_CHROMA_ZERO);
        p = x * $signed({23'h00_0000, g}) * $signed({22'h00_0000, r});
        y = (p + $signed(`CSA_ROUND)) >>> `CSA_RECIP_SHIFT;
        o = 32'(y + $signed(`CSA_CHROMA_ZERO));
        if (y + $signed(`CSA_CHROMA_ZERO) <
            $signed({24'h00_0000, `CSA_CHROMA_MIN})) begin
            return `CSA_CHROMA_MIN;
        end else if (y + $signed(`CSA_CHROMA_ZERO) >
                     $signed({24'h00_0000, `CSA_CHROMA_MAX})) begin
            return `CSA_CHROMA_MAX;
        end
        return o[7:0];
    endfunction

    // hue code times the per-step phase increment, two's complement
    assign hue_offset = $signed({{8{hue_q[7]}}, hue_q})
                      * $signed(`CSA_HUE_PHASE_STEP);

    // the whole sample is computed from one snapshot of the settings
    // in the cycle it is accepted, so no pixel mixes old and new
    always_comb begin
        adj_pix.u     = csa_scale(i_in_pix.u, u_gain_value,
                                  `CSA_U_RECIP);
        adj_pix.v     = csa_scale(i_in_pix.v, v_gain_value,
                                  `CSA_V_RECIP);
        adj_pix.phase = 16'(i_in_pix.phase + hue_offset);
    end

    assign in_fire = i_in_valid && o_in_ready;

    // ****************************************************************
    // luma filter selection
    // ****************************************************************
    function automatic csa_luma_mode_t csa_luma_decode(
        input logic [7:0] lc);
        logic [1:0] hf;
        hf = lc[`CSA_LOOP_HF_HI:`CSA_LOOP_HF_LO];
        if (lc[`CSA_LOOP_PEAK]) begin
            unique case (hf)
                2'b00: return CSA_PEAK_NONE;
                2'b01: return CSA_PEAK_MIN;
                2'b10: return CSA_PEAK_MED;
                2'b11: return CSA_PEAK_MAX;
            endcase
        end
        unique case (hf)
            2'b00: return CSA_LP_AUTO;
            2'b01: return CSA_LP_CIF;
            2'b10: return CSA_LP_QCIF;
            2'b11: return CSA_LP_ICON;
        endcase
        return CSA_LP_AUTO;
    endfunction

    assign o_luma_mode = csa_luma_decode(loop_sel);

    // ****************************************************************
    // output buffer
    // ****************************************************************
    csa_fifo #(
        .WIDTH ($bits(csa_pix_t)),
        .DEPTH (`CSA_FIFO_DEPTH)
    ) u_out_fifo (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_s_valid (i_in_valid),
        .o_s_ready (o_in_ready),
        .i_s_data  (adj_pix),
        .o_m_valid (o_out_valid),
        .i_m_ready (i_out_ready),
        .o_m_data  (o_out_pix)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb_adj @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    chk_gain_reset_val : assert property (
        $fell(i_reset) |-> u_low_q == `CSA_RST_U_LOW
                        && v_low_q == `CSA_RST_V_LOW
                        && hue_q == `CSA_RST_HUE
                        && even_loop_q == `CSA_RST_LOOP
                        && odd_loop_q == `CSA_RST_LOOP)
        else $error("settings not at reset values");
    chk_read_one_cycle : assert property (
        i_reg.rd && i_reg.addr == `CSA_OFF_U_LOW
        |=> o_rdata == $past(u_low_q))
        else $error("u gain low byte read back wrong");
    chk_u_write_gain : assert property (
        csa_wr_hit(i_reg, `CSA_OFF_U_LOW) && !i_reg.rd
        |=> u_gain_value[7:0] == $past(i_reg.wdata))
        else $error("u gain low byte not applied");
    chk_u_unity_pass : assert property (
        in_fire && u_gain_value == `CSA_U_UNITY
        && i_in_pix.u >= `CSA_CHROMA_MIN && i_in_pix.u <= `CSA_CHROMA_MAX
        |-> adj_pix.u == i_in_pix.u)
        else $error("u unity gain alters sample");
    chk_v_unity_pass : assert property (
        in_fire && v_gain_value == `CSA_V_UNITY
        && i_in_pix.v >= `CSA_CHROMA_MIN && i_in_pix.v <= `CSA_CHROMA_MAX
        |-> adj_pix.v == i_in_pix.v)
        else $error("v unity gain alters sample");
    chk_chroma_clip : assert property (
        in_fire |-> adj_pix.u >= `CSA_CHROMA_MIN
                 && adj_pix.u <= `CSA_CHROMA_MAX
                 && adj_pix.v >= `CSA_CHROMA_MIN
                 && adj_pix.v <= `CSA_CHROMA_MAX)
        else $error("scaled chroma outside legal range");
    chk_hue_phase_add : assert property (
        in_fire && hue_q == 8'h80
        |-> adj_pix.phase == 16'(i_in_pix.phase - 16'h3f80))
        else $error("hue offset not added to phase");
    chk_field_loop_sel : assert property (
        i_field_odd && odd_loop_q[`CSA_LOOP_PEAK]
        && odd_loop_q[`CSA_LOOP_HF_HI:`CSA_LOOP_HF_LO] == 2'b01
        |-> o_luma_mode == CSA_PEAK_MIN)
        else $error("odd field loop control not applied");
    chk_lowpass_sel : assert property (
        !loop_sel[`CSA_LOOP_PEAK] |-> o_luma_mode inside
        {CSA_LP_AUTO, CSA_LP_CIF, CSA_LP_QCIF, CSA_LP_ICON})
        else $error("peaking chosen with peak bit clear");

    cov_max_u_gain  : cover property (in_fire && u_gain_value == 9'h1ff);
    cov_peak_max    : cover property (o_luma_mode == CSA_PEAK_MAX);
    cov_stall_input : cover property (i_in_valid && !o_in_ready);

endmodule // csa_adjust

// >>> bench/chroma_saturation_hue_adjust_bench.sv
// Purpose : self-checking bench for the chroma saturation / hue stage
// Assumes : 200 MHz clock, register reads answer one cycle after rd
// Notes   : expectations come from a register model kept in the bench
`timescale 1ns/1ps
`include "csa_consts.svh"

module chroma_saturation_hue_adjust_bench;
    import csa_pkg::*;

    // ****************************************************************
    // signals and model state
    // ****************************************************************
    logic           i_sys_clk  = 1'b0;
    logic           i_reset    = 1'b1;
    csa_reg_req_t   req        = '0;
    logic [7:0]     o_rdata;
    logic           field_odd  = 1'b0;
    logic           in_valid   = 1'b0;
    logic           o_in_ready;
    csa_pix_t       in_pix     = '0;
    logic           o_out_valid;
    logic           out_ready  = 1'b0;
    csa_pix_t       o_out_pix;
    csa_luma_mode_t o_luma_mode;
    int             fail_count = 0;
    int             n_checks   = 0;
    logic [7:0]     ctl_m [2]  = '{8'h20, 8'h20};
    logic [7:0]     lp_m [2]   = '{8'h00, 8'h00};
    logic [7:0]     ulow_m     = 8'hfe;
    logic [7:0]     vlow_m     = 8'hb4;
    logic [7:0]     hue_m      = 8'h00;
    csa_pix_t       expq [$];

    localparam logic [7:0] ADDRS [9] = '{`CSA_OFF_EVEN_CTL, `CSA_OFF_ODD_CTL,
        `CSA_OFF_U_LOW, `CSA_OFF_V_LOW, `CSA_OFF_HUE, `CSA_OFF_EVEN_LOOP,
        `CSA_OFF_ODD_LOOP, 8'h44, 8'h00};
    localparam logic [7:0] LT [8] = '{8'h00, 8'h08, 8'h10, 8'h18,
        8'h80, 8'h88, 8'h90, 8'h98};

    always #2.5 i_sys_clk = ~i_sys_clk;

    csa_adjust dut (
        .i_sys_clk   (i_sys_clk),
        .i_reset     (i_reset),
        .i_reg       (req),
        .o_rdata     (o_rdata),
        .i_field_odd (field_odd),
        .i_in_valid  (in_valid),
        .o_in_ready  (o_in_ready),
        .i_in_pix    (in_pix),
        .o_out_valid (o_out_valid),
        .i_out_ready (out_ready),
        .o_out_pix   (o_out_pix),
        .o_luma_mode (o_luma_mode)
    );

    // ****************************************************************
    // compare tasks and model
    // ****************************************************************
    task automatic cmp_reg(input string w, input logic [7:0] e,
                           input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic cmp_pix(input csa_pix_t e, input csa_pix_t g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value out pixel expected %h seen %h", e, g);
        end
    endtask

    task automatic cmp_mode(input csa_luma_mode_t e);
        n_checks++;
        if (o_luma_mode !== e) begin
            fail_count++;
            $display("wrong value luma mode expected %0d seen %0d",
                     e, o_luma_mode);
        end
    endtask

    function automatic logic [7:0] model_rd(input logic [7:0] a);
        case (a)
            `CSA_OFF_EVEN_CTL:  return ctl_m[0];
            `CSA_OFF_ODD_CTL:   return ctl_m[1];
            `CSA_OFF_U_LOW:     return ulow_m;
            `CSA_OFF_V_LOW:     return vlow_m;
            `CSA_OFF_HUE:       return hue_m;
            `CSA_OFF_EVEN_LOOP: return lp_m[0];
            `CSA_OFF_ODD_LOOP:  return lp_m[1];
            default:            return 8'h00;
        endcase
    endfunction

    // offset-binary chroma scaled, rounded and clipped to 2..253
    function automatic logic [7:0] scale(input logic [7:0] c, input int g,
                                         input int r);
        int d;
        d = (((int'(c) - 128) * g * r) + 32768) >>> 16;
        d = d + 128;
        if (d < 2) d = 2;
        if (d > 253) d = 253;
        return d[7:0];
    endfunction

    function automatic csa_pix_t exp_pix(input csa_pix_t p, input logic o);
        csa_pix_t r;
        r.phase = p.phase + 16'($signed(hue_m) * 127);
        r.u = scale(p.u, int'({ctl_m[o][1], ulow_m}), `CSA_U_RECIP);
        r.v = scale(p.v, int'({ctl_m[o][0], vlow_m}), `CSA_V_RECIP);
        return r;
    endfunction

    // ****************************************************************
    // bus and stream tasks
    // ****************************************************************
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge i_sys_clk);
        req.wr    <= 1'b0;
        case (a)
            `CSA_OFF_EVEN_CTL:  ctl_m[0] = d;
            `CSA_OFF_ODD_CTL:   ctl_m[1] = d;
            `CSA_OFF_U_LOW:     ulow_m = d;
            `CSA_OFF_V_LOW:     vlow_m = d;
            `CSA_OFF_HUE:       hue_m = d;
            `CSA_OFF_EVEN_LOOP: lp_m[0] = d;
            `CSA_OFF_ODD_LOOP:  lp_m[1] = d;
            default:            ;
        endcase
    endtask

    task automatic check_regs();
        foreach (ADDRS[i]) begin
            @(posedge i_sys_clk);
            req.rd   <= 1'b1;
            req.addr <= ADDRS[i];
            @(posedge i_sys_clk);
            req.rd   <= 1'b0;
            #1 cmp_reg($sformatf("reg %h", ADDRS[i]), model_rd(ADDRS[i]),
                       o_rdata);
        end
    endtask

    task automatic push(input csa_pix_t p, input logic o);
        int k;
        k = 0;
        @(posedge i_sys_clk);
        in_valid  <= 1'b1;
        in_pix    <= p;
        field_odd <= o;
        expq.push_back(exp_pix(p, o));
        @(negedge i_sys_clk);
        while (o_in_ready !== 1'b1 && k < 50) begin
            @(negedge i_sys_clk);
            k++;
        end
        if (k == 50) fail_count++;
        @(posedge i_sys_clk);
        in_valid <= 1'b0;
    endtask

    task automatic pop();
        int k;
        k = 0;
        @(negedge i_sys_clk);
        while (o_out_valid !== 1'b1 && k < 50) begin
            @(negedge i_sys_clk);
            k++;
        end
        if (k == 50) fail_count++;
        cmp_pix(expq.pop_front(), o_out_pix);
        @(posedge i_sys_clk);
        out_ready <= 1'b1;
        @(posedge i_sys_clk);
        out_ready <= 1'b0;
    endtask

    function automatic csa_pix_t mk(input int i);
        return '{16'h0123 + 16'(i * 16'h1000), 8'h10 + 8'(i * 28),
                 8'hf0 - 8'(i * 28)};
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        $display("watchdog expired");
        test_done();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        check_regs();
        $display("test reset values done");
        push('{16'h4000, 8'h02, 8'hfd}, 1'b0);
        push('{16'hfff0, 8'hfd, 8'h02}, 1'b1);
        push('{16'h0001, 8'h80, 8'h37}, 1'b0);
        repeat (3) pop();
        $display("test unity gain done");
        reg_wr(`CSA_OFF_EVEN_CTL, 8'h23);
        reg_wr(`CSA_OFF_ODD_CTL, 8'h21);
        reg_wr(`CSA_OFF_U_LOW, 8'hfc);
        reg_wr(`CSA_OFF_V_LOW, 8'h68);
        reg_wr(`CSA_OFF_HUE, 8'h80);
        reg_wr(8'h44, 8'h5a);
        check_regs();
        $display("test register access done");
        for (int i = 0; i < 4; i++) push(mk(i), i[0]);
        reg_wr(`CSA_OFF_HUE, 8'h7f);
        for (int i = 4; i < 8; i++) push(mk(i), i[0]);
        @(posedge i_sys_clk);
        in_valid  <= 1'b1;
        in_pix    <= mk(8);
        field_odd <= 1'b0;
        expq.push_back(exp_pix(mk(8), 1'b0));
        repeat (3) begin
            @(negedge i_sys_clk);
            cmp_reg("in ready full", 8'h00, {7'h0, o_in_ready});
        end
        pop();
        @(negedge i_sys_clk);
        cmp_reg("in ready after pop", 8'h01, {7'h0, o_in_ready});
        @(posedge i_sys_clk);
        in_valid <= 1'b0;
        repeat (8) pop();
        @(negedge i_sys_clk);
        cmp_reg("out valid empty", 8'h00, {7'h0, o_out_valid});
        $display("test gain hue fifo done");
        for (int i = 0; i < 8; i++) begin
            reg_wr(`CSA_OFF_EVEN_LOOP, LT[i]);
            reg_wr(`CSA_OFF_ODD_LOOP, LT[7 - i]);
            @(posedge i_sys_clk);
            field_odd <= 1'b0;
            @(negedge i_sys_clk);
            cmp_mode(csa_luma_mode_t'(i));
            @(posedge i_sys_clk);
            field_odd <= 1'b1;
            @(negedge i_sys_clk);
            cmp_mode(csa_luma_mode_t'(7 - i));
        end
        $display("test luma mode done");
        test_done();
    end

endmodule // chroma_saturation_hue_adjust_bench
